//--- dio_pkg.sv
// constants and types for the digit transfer and fault flag block
package dio_pkg;
  localparam logic [3:0] MDC_RESET      = 4'h8;
  localparam logic [3:0] MDC_MIN        = 4'h1;
  localparam logic [3:0] MDC_MAX        = 4'h8;
  localparam logic [3:0] ADDR_SCI_FIRST = 4'h0;
  localparam logic [3:0] ADDR_EXP_LS    = 4'h1;
  localparam logic [3:0] ADDR_SIGN      = 4'h2;
  localparam logic [3:0] ADDR_FP_FIRST  = 4'h2;
  localparam logic [3:0] ADDR_POINT     = 4'h3;
  localparam logic [3:0] ADDR_MANT      = 4'h4;
  localparam logic [3:0] ADDR_IDLE      = 4'h0;
  localparam logic [3:0] LAST_OFFSET    = 4'h3;
  localparam logic [3:0] POINT_TOP      = 4'hB;
  localparam logic [3:0] ENTRY_MAX      = 4'h8;
  localparam logic [1:0] BOOT_SKIP      = 2'h3;
  localparam logic [1:0] SAMPLE_WAIT    = 2'h2;
  localparam logic       SCI_RESET      = 1'b1;
  localparam int unsigned MANT_DIGITS   = 8;

  // instruction classes seen by this block
  typedef enum logic [3:0] {
    OP_NOP, OP_READ_MULTI, OP_WRITE_MULTI, OP_ENTRY_DIGIT, OP_SET_COUNT,
    OP_FAULT_CLEAR, OP_FAULT_TEST, OP_PUSH, OP_FUNC, OP_SET_SCI, OP_SET_FP
  } dio_op_t;

  typedef struct packed {
    dio_op_t    op;
    logic [3:0] arg;
  } dio_instr_t;

  // digit 0 is the most significant
  typedef logic [MANT_DIGITS-1:0][3:0] dio_mant_t;

  typedef struct packed {
    logic            mant_sign;
    logic            exp_sign;
    logic [1:0][3:0] exp_digits;
    dio_mant_t       mant;
    logic [3:0]      point_code;
    logic            below_one;
  } dio_num_t;
endpackage : dio_pkg

//--- dio_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dio_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  genvar i;
  // one pair per bit, first stage read only by the second
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate
endmodule : dio_sync
`default_nettype wire

//--- dio_format_core.sv
// digit bus sequencing, number entry, fault flag and run control
`timescale 1ns/1ps
`default_nettype none
module dio_format_core (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire dio_pkg::dio_instr_t instr_pins,
  input  wire logic                stall_pin,
  input  wire logic [3:0]          digit_read_bus,
  input  wire logic                fault_event,
  input  wire logic                err8_active,
  input  wire dio_pkg::dio_num_t   x_value,
  output logic                     ready,
  output logic                     fault_flag,
  output logic                     jump_taken_pulse,
  output logic [3:0]               digit_address_bus,
  output logic                     digit_addr_strobe_b,
  output logic [3:0]               digit_write_bus,
  output logic                     write_strobe_b,
  output var dio_pkg::dio_num_t    read_value,
  output var dio_pkg::dio_mant_t   x_mantissa,
  output logic [3:0]               point_index,
  output logic                     entry_active,
  output logic [3:0]               mant_count,
  output logic                     sci_mode
);
  import dio_pkg::*;

  typedef enum logic [2:0] {S_BOOT, S_FETCH, S_EXEC, S_ADDR, S_DATA, S_END} dio_state_t;

  logic [12:0] sync_q;
  dio_instr_t  instr_s;
  logic        stall_s;
  logic [3:0]  rd_s;
  dio_state_t  state_reg, state_next;
  dio_instr_t  instr_reg;
  logic [1:0]  boot_cnt_reg;
  logic [3:0]  addr_cnt_reg;
  logic [1:0]  wait_cnt_reg;
  logic        ain_reg, wr_reg;
  logic        fault_reg, jump_reg, ready_reg;
  logic [3:0]  addr_bus_reg, wbus_reg;
  logic        strobe_b_reg, wstrobe_b_reg;
  dio_num_t    read_reg;
  dio_mant_t   xm_reg;
  logic [3:0]  point_reg, entry_cnt_reg, mdc_reg;
  logic        entry_reg, sci_reg;
  logic [3:0]  last_addr;
  logic        is_exec, suppress, xfer_op, sample, last_hit;

  // pins cross in through two flops
  dio_sync #(.W(13)) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .d       ({instr_pins, stall_pin, digit_read_bus}),
    .q       (sync_q)
  );
  assign instr_s = dio_instr_t'(sync_q[12:5]);
  assign stall_s = sync_q[4];
  assign rd_s    = sync_q[3:0];

  assign is_exec   = (state_reg == S_EXEC);
  assign last_addr = mdc_reg + LAST_OFFSET;
  assign suppress  = (instr_reg.op == OP_WRITE_MULTI) && err8_active;
  assign xfer_op   = (instr_reg.op == OP_READ_MULTI) || (instr_reg.op == OP_WRITE_MULTI);
  assign sample    = (state_reg == S_DATA) && (wait_cnt_reg == SAMPLE_WAIT);
  assign last_hit  = (addr_cnt_reg == last_addr);

  // outgoing digit for an address; packing per mode
  function automatic logic [3:0] out_digit(input logic [3:0] a);
    logic [3:0] d;
    logic [2:0] idx;
    idx = 3'(a - ADDR_MANT);
    d   = x_value.mant[idx];
    if (sci_reg && a == ADDR_SCI_FIRST)
      d = x_value.exp_digits[0];
    else if (sci_reg && a == ADDR_EXP_LS)
      d = x_value.exp_digits[1];
    else if (a == ADDR_SIGN)
      d = {x_value.mant_sign, 2'h0, sci_reg & x_value.exp_sign};
    else if (a == ADDR_POINT)
      d = sci_reg ? 4'h0 : (x_value.below_one ? POINT_TOP : x_value.point_code);
    else if (!sci_reg && x_value.below_one && idx == 3'h0)
      d = 4'h0;
    return d;
  endfunction : out_digit

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_BOOT:  if (boot_cnt_reg == BOOT_SKIP - 2'h1) state_next = S_FETCH;
      S_FETCH: if (!stall_s) state_next = S_EXEC;
      S_EXEC: begin
        if (xfer_op && !suppress)
          state_next = S_ADDR;
        else if (instr_reg.op == OP_ENTRY_DIGIT && entry_cnt_reg < ENTRY_MAX)
          state_next = S_ADDR;
        else
          state_next = S_FETCH;
      end
      S_ADDR:  state_next = S_DATA;
      S_DATA: begin
        if (wait_cnt_reg == SAMPLE_WAIT) begin
          if (ain_reg)       state_next = S_FETCH;
          else if (last_hit) state_next = S_END;
          else               state_next = S_ADDR;
        end
      end
      S_END:   state_next = S_FETCH;
      default: state_next = S_BOOT;
    endcase
  end

  // state, boot count and latched instruction
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg    <= S_BOOT;
      boot_cnt_reg <= 2'h0;
      instr_reg    <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == S_BOOT) boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (state_reg == S_FETCH && !stall_s) instr_reg <= instr_s;
    end
  end

  // ready high while stalled or fetching
  always_ff @(posedge ref_clk) begin
    if (!rst_b) ready_reg <= 1'b0;
    else ready_reg <= stall_s || state_reg == S_FETCH || state_reg == S_BOOT;
  end

  // transfer bookkeeping
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      addr_cnt_reg <= ADDR_IDLE;
      wait_cnt_reg <= 2'h0;
      ain_reg      <= 1'b0;
      wr_reg       <= 1'b0;
    end else begin
      if (is_exec) begin
        ain_reg <= (instr_reg.op == OP_ENTRY_DIGIT);
        wr_reg  <= (instr_reg.op == OP_WRITE_MULTI);
        // start point per mode, entry uses its count
        addr_cnt_reg <= (instr_reg.op == OP_ENTRY_DIGIT) ? entry_cnt_reg :
                        (sci_reg ? ADDR_SCI_FIRST : ADDR_FP_FIRST);
      end
      if (state_reg == S_ADDR) wait_cnt_reg <= 2'h0;
      else if (state_reg == S_DATA) wait_cnt_reg <= wait_cnt_reg + 2'h1;
      if (sample && !ain_reg && !last_hit) addr_cnt_reg <= addr_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      addr_bus_reg <= ADDR_IDLE;
      strobe_b_reg <= 1'b1;
    end else begin
      case (state_reg)
        S_ADDR: begin
          addr_bus_reg <= addr_cnt_reg;
          strobe_b_reg <= 1'b0;
        end
        S_END: begin
          addr_bus_reg <= ADDR_IDLE;
          strobe_b_reg <= 1'b0;
        end
        default: strobe_b_reg <= 1'b1;
      endcase
    end
  end

  // write data set up with the address, strobe one cycle after
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wbus_reg      <= 4'h0;
      wstrobe_b_reg <= 1'b1;
    end else begin
      if (state_reg == S_ADDR && wr_reg) wbus_reg <= out_digit(addr_cnt_reg);
      wstrobe_b_reg <= !(state_reg == S_DATA && wr_reg && wait_cnt_reg == 2'h0);
    end
  end

  // read capture; bus is sampled late to cover synchroniser delay
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      read_reg <= '0;
    end else if (sample && !ain_reg && !wr_reg) begin
      if (sci_reg && addr_cnt_reg == ADDR_SCI_FIRST)
        read_reg.exp_digits[0] <= rd_s;
      else if (sci_reg && addr_cnt_reg == ADDR_EXP_LS)
        read_reg.exp_digits[1] <= rd_s;
      else if (addr_cnt_reg == ADDR_SIGN) begin
        read_reg.mant_sign <= rd_s[3];
        read_reg.exp_sign  <= sci_reg & rd_s[0];
      end else if (addr_cnt_reg == ADDR_POINT) begin
        if (!sci_reg) read_reg.point_code <= rd_s;
      end else
        read_reg.mant[3'(addr_cnt_reg - ADDR_MANT)] <= rd_s;
    end
  end

  // number entry; a new number clears stale digits on its first digit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      xm_reg        <= '0;
      point_reg     <= 4'h0;
      entry_reg     <= 1'b0;
      entry_cnt_reg <= 4'h0;
    end else if (sample && ain_reg) begin
      if (!entry_reg) xm_reg <= '0;
      xm_reg[entry_cnt_reg[2:0]] <= rd_s;
      entry_reg     <= 1'b1;
      entry_cnt_reg <= entry_cnt_reg + 4'h1;
      point_reg     <= entry_cnt_reg + 4'h1;
    end else if (is_exec && (instr_reg.op == OP_PUSH || instr_reg.op == OP_FUNC)) begin
      entry_reg     <= 1'b0;
      entry_cnt_reg <= 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mdc_reg <= MDC_RESET;
      sci_reg <= SCI_RESET;
    end else if (is_exec) begin
      if (instr_reg.op == OP_SET_COUNT)
        mdc_reg <= (instr_reg.arg < MDC_MIN) ? MDC_MIN :
                   (instr_reg.arg > MDC_MAX) ? MDC_MAX : instr_reg.arg;
      if (instr_reg.op == OP_SET_SCI) sci_reg <= 1'b1;
      if (instr_reg.op == OP_SET_FP)  sci_reg <= 1'b0;
    end
  end

  // fault flag: a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fault_reg <= 1'b0;
      jump_reg  <= 1'b0;
    end else begin
      if (fault_event) fault_reg <= 1'b1;
      else if (is_exec && instr_reg.op == OP_FAULT_CLEAR) fault_reg <= 1'b0;
      jump_reg <= is_exec && instr_reg.op == OP_FAULT_TEST && fault_reg;
    end
  end

  assign ready               = ready_reg;
  assign fault_flag          = fault_reg;
  assign jump_taken_pulse    = jump_reg;
  assign digit_address_bus   = addr_bus_reg;
  assign digit_addr_strobe_b = strobe_b_reg;
  assign digit_write_bus     = wbus_reg;
  assign write_strobe_b      = wstrobe_b_reg;
  assign read_value          = read_reg;
  assign x_mantissa          = xm_reg;
  assign point_index         = point_reg;
  assign entry_active        = entry_reg;
  assign mant_count          = mdc_reg;
  assign sci_mode            = sci_reg;

  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence xfer_go;
    is_exec && (instr_reg.op == OP_READ_MULTI ||
                (instr_reg.op == OP_WRITE_MULTI && !err8_active));
  endsequence
  sequence strobe_frame;
    !digit_addr_strobe_b ##1 digit_addr_strobe_b;
  endsequence

  first_addr_a: assert property (xfer_go |-> ##2 !digit_addr_strobe_b &&
    digit_address_bus == (sci_reg ? ADDR_SCI_FIRST : ADDR_FP_FIRST))
    else $error("first digit address wrong");
  strobe_width_a: assert property ($fell(digit_addr_strobe_b) |-> strobe_frame)
    else $error("address strobe not one cycle");
  end_addr_a: assert property (state_reg == S_END |=>
    digit_address_bus == ADDR_IDLE && !digit_addr_strobe_b)
    else $error("no final strobe at address zero");
  fault_hold_a: assert property (fault_flag && !(is_exec &&
    instr_reg.op == OP_FAULT_CLEAR) |=> fault_flag)
    else $error("fault flag dropped without clear");
  fault_set_a: assert property (fault_event |=> fault_flag)
    else $error("fault flag not raised");
  jump_pulse_a: assert property (is_exec && instr_reg.op == OP_FAULT_TEST
    |=> jump_taken_pulse == $past(fault_reg))
    else $error("jump pulse does not follow flag");
  stall_ready_a: assert property (stall_s |=> ready)
    else $error("ready low while stalled");
  write_skip_a: assert property (is_exec && suppress |=>
    digit_addr_strobe_b [*3])
    else $error("write ran under error 8");
  count_reset_a: assert property (!$past(rst_b) |-> mant_count == MDC_RESET)
    else $error("count not 8 after reset");
  entry_limit_a: assert property (entry_cnt_reg <= ENTRY_MAX)
    else $error("more than 8 entry digits");
  boot_skip_a: assert property (!$past(rst_b) |-> ##3 state_reg == S_FETCH)
    else $error("boot skip length wrong");
endmodule : dio_format_core
`default_nettype wire

//--- dio_far_model.sv
// far-side model: digit ram on the buses and the outside program sequencer
`timescale 1ns/1ps
`default_nettype none
module dio_far_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] digit_address_bus,
  input  wire logic [3:0] digit_write_bus,
  input  wire logic       write_strobe_b,
  input  wire logic       ready,
  input  wire logic       fault_flag,
  output logic      [3:0] digit_read_bus
);
  logic [3:0] mem [16];
  logic [7:0] seq_reg;
  logic       ready_d;

  // one bcd digit per address, always driven like a latch bank
  assign digit_read_bus = mem[digit_address_bus];

  // capture a written digit; plain always so the bench may preload mem
  always @(posedge ref_clk) begin
    if (write_strobe_b === 1'b0) begin
      mem[digit_address_bus] <= digit_write_bus;
    end
  end

  // fault clears the sequencer at once, ready rise steps it
  always @(posedge ref_clk or posedge fault_flag) begin
    if (fault_flag) begin
      seq_reg <= 8'h00;
    end else if (ready && !ready_d) begin
      seq_reg <= seq_reg + 8'h01;
    end
    ready_d <= ready;
  end
endmodule : dio_far_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the digit transfer and fault flag block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dio_pkg::*;
  logic       ref_clk, rst_b, stall_pin, fault_event, err8_active;
  logic       ready, fault_flag, jump_taken_pulse, digit_addr_strobe_b;
  logic       write_strobe_b, entry_active, sci_mode, rdy_d;
  logic [3:0] digit_read_bus, digit_address_bus, digit_write_bus;
  logic [3:0] point_index, mant_count;
  dio_instr_t instr_pins;
  dio_num_t   x_value, read_value;
  dio_mant_t  x_mantissa;
  logic [3:0] addr_q[$];
  logic [7:0] wr_q[$];
  logic [3:0] img [16];
  logic [7:0] w;
  logic [31:0] rng;
  int         mismatches, samples_checked, jumps, rises;

  dio_format_core dio_format_core_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .instr_pins(instr_pins), .stall_pin(stall_pin), .digit_read_bus(digit_read_bus),
    .fault_event(fault_event), .err8_active(err8_active), .x_value(x_value),
    .ready(ready), .fault_flag(fault_flag), .jump_taken_pulse(jump_taken_pulse),
    .digit_address_bus(digit_address_bus), .digit_addr_strobe_b(digit_addr_strobe_b),
    .digit_write_bus(digit_write_bus), .write_strobe_b(write_strobe_b),
    .read_value(read_value), .x_mantissa(x_mantissa), .point_index(point_index),
    .entry_active(entry_active), .mant_count(mant_count), .sci_mode(sci_mode));

  dio_far_model dio_far_model_i (.ref_clk(ref_clk), .digit_address_bus(digit_address_bus),
    .digit_write_bus(digit_write_bus), .write_strobe_b(write_strobe_b), .ready(ready),
    .fault_flag(fault_flag), .digit_read_bus(digit_read_bus));

  // free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // one stall-low cycle lets exactly one instruction through the fetch
  task automatic issue(input dio_op_t op, input logic [3:0] arg);
    instr_pins = '{op, arg};
    repeat (3) @(negedge ref_clk);
    stall_pin = 1'b0;
    @(negedge ref_clk);
    stall_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask : issue

  // bounded wait until every noted strobe has been seen
  task automatic drain();
    int n;
    n = 0;
    while (addr_q.size() + wr_q.size() != 0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk("transfer hang", 4'h0, (n == 400) ? 4'h1 : 4'h0);
    repeat (4) @(negedge ref_clk);
  endtask : drain

  // note the address walk and, for writes, each digit expected on the bus
  task automatic plan(input logic wr, input logic sci, input int mdc);
    logic [3:0] d;
    for (int a = sci ? 0 : 2; a <= mdc + 3; a++) begin
      case (a)
        0: d = x_value.exp_digits[0];
        1: d = x_value.exp_digits[1];
        2: d = {x_value.mant_sign, 2'b00, sci & x_value.exp_sign};
        3: d = sci ? 4'h0 : (x_value.below_one ? POINT_TOP : x_value.point_code);
        4: d = (!sci && x_value.below_one) ? 4'h0 : x_value.mant[0];
        default: d = x_value.mant[a - 4];
      endcase
      addr_q.push_back(4'(a));
      if (wr) wr_q.push_back({4'(a), d});
    end
    addr_q.push_back(ADDR_IDLE);
  endtask : plan

  // watcher: strobes take the oldest note; a strobe with no note is stray
  always @(posedge ref_clk) begin
    if (rst_b && digit_addr_strobe_b === 1'b0) begin
      if (addr_q.size() == 0) chk("stray strobe", 4'h0, 4'h1);
      else chk("address", addr_q.pop_front(), digit_address_bus);
    end
    if (rst_b && write_strobe_b === 1'b0) begin
      w = (wr_q.size() == 0) ? 8'hFF : wr_q.pop_front();
      chk("write addr", w[7:4], digit_address_bus);
      chk("write digit", w[3:0], digit_write_bus);
    end
    if (jump_taken_pulse === 1'b1) jumps++;
    if (ready === 1'b1 && rdy_d === 1'b0) rises++;
    rdy_d = ready;
  end

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #(8 * 20000);
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    stall_pin = 1'b1;
    fault_event = 1'b0;
    err8_active = 1'b0;
    x_value = '0;
    instr_pins = '0;
    mismatches = 0;
    samples_checked = 0;
    jumps = 0;
    rises = 0;
    rng = 32'h0F15;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("count", 4'h8, mant_count);
    chk("ready held", 4'h1, {3'h0, ready});
    stall_pin = 1'b0;
    rises = 0;
    repeat (20) @(negedge ref_clk);
    stall_pin = 1'b1;
    chk("ready pulses", 4'h1, {3'h0, rises >= 5});
    repeat (6) @(negedge ref_clk);
    $display("test run control done");
    // random bcd digits; leading mantissa digit kept nonzero
    for (int a = 0; a < 12; a++) begin
      rng = xs(rng);
      img[a] = (a == 4) ? 4'(rng % 9 + 1) : 4'(rng % 10);
      dio_far_model_i.mem[a] = (a == 2) ? 4'h9 : img[a];
    end
    plan(1'b0, 1'b1, 8);
    issue(OP_READ_MULTI, 4'h0);
    drain();
    chk("signs", 4'h9, {read_value.mant_sign, 2'b00, read_value.exp_sign});
    chk("exp high", img[0], read_value.exp_digits[0]);
    chk("exp low", img[1], read_value.exp_digits[1]);
    for (int a = 0; a < 8; a++) chk("mantissa", img[a + 4], read_value.mant[a]);
    $display("test scientific read done");
    x_value.exp_digits[0] = img[0];
    x_value.exp_digits[1] = img[1];
    x_value.mant_sign = 1'b1;
    x_value.exp_sign = 1'b1;
    for (int a = 0; a < 8; a++) x_value.mant[a] = img[a + 4];
    plan(1'b1, 1'b1, 8);
    issue(OP_WRITE_MULTI, 4'h0);
    drain();
    $display("test scientific write done");
    issue(OP_SET_COUNT, 4'h4);
    chk("count", 4'h4, mant_count);
    issue(OP_SET_FP, 4'h0);
    chk("mode", 4'h0, {3'h0, sci_mode});
    x_value.point_code = 4'hA;
    for (int k = 0; k < 2; k++) begin
      x_value.below_one = k[0];
      plan(1'b1, 1'b0, 4);
      issue(OP_WRITE_MULTI, 4'h0);
      drain();
    end
    // read back what the last floating write left in the ram
    plan(1'b0, 1'b0, 4);
    issue(OP_READ_MULTI, 4'h0);
    drain();
    chk("fp signs", 4'h8, {read_value.mant_sign, 2'b00, read_value.exp_sign});
    chk("point code", POINT_TOP, read_value.point_code);
    chk("fp lead digit", 4'h0, read_value.mant[0]);
    chk("fp mantissa", img[5], read_value.mant[1]);
    $display("test floating write done");
    fault_event = 1'b1;
    @(negedge ref_clk);
    fault_event = 1'b0;
    err8_active = 1'b1;
    issue(OP_WRITE_MULTI, 4'h0);
    repeat (40) @(negedge ref_clk);
    err8_active = 1'b0;
    chk("fault set", 4'h1, {3'h0, fault_flag});
    chk("sequencer clear", 4'h0, dio_far_model_i.seq_reg[3:0]);
    plan(1'b1, 1'b0, 4);
    issue(OP_WRITE_MULTI, 4'h0);
    drain();
    chk("fault held", 4'h1, {3'h0, fault_flag});
    jumps = 0;
    issue(OP_FAULT_TEST, 4'h0);
    chk("jump", 4'h1, 4'(jumps));
    issue(OP_FAULT_CLEAR, 4'h0);
    chk("fault clear", 4'h0, {3'h0, fault_flag});
    jumps = 0;
    issue(OP_FAULT_TEST, 4'h0);
    chk("no jump", 4'h0, 4'(jumps));
    // sequencer must step again once the flag is gone
    stall_pin = 1'b0;
    repeat (10) @(negedge ref_clk);
    stall_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("sequencer step", 4'h1, {3'h0, dio_far_model_i.seq_reg != 8'h00});
    $display("test fault flag done");
    for (int i = 0; i < 8; i++) begin
      addr_q.push_back(4'(i));
      dio_far_model_i.mem[i] = img[i + 4];
      issue(OP_ENTRY_DIGIT, 4'h0);
    end
    drain();
    chk("entry on", 4'h1, {3'h0, entry_active});
    for (int i = 0; i < 8; i++) chk("entered", img[i + 4], x_mantissa[i]);
    chk("point", 4'h8, point_index);
    issue(OP_PUSH, 4'h0);
    chk("entry off", 4'h0, {3'h0, entry_active});
    $display("test digit entry done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
